// ---- rtl/fpw_pkg.sv ----
// Package of constants and types for the parallel word-port memory host controller
// Behaviour
// RULE_01 - Device decodes an 18-bit word address into one of 262,144 words.
// RULE_02 - Reads and writes share one 16-bit bidirectional data bus.
// RULE_03 - Select falling edge starts an access and latches the whole address.
// RULE_04 - With select low, changing only the two low address lines gives page access.
// RULE_05 - Host reaches another row by new select low or upper address change.
// RULE_06 - A cycle starts on select falling edge or by address change alone.
// RULE_07 - Write strobe low begins a write; its rising edge stores bus data.
// RULE_08 - In page writes each write strobe fall takes a new column address.
// RULE_09 - With output enable low, device drives bus only once data is valid.
// RULE_10 - Output enable high puts all data pins in high impedance.
// RULE_11 - Upper and lower lane selects gate their byte for reads and writes.
// RULE_12 - Lane selects let host use the memory as 512K x 8 bytes.
// RULE_13 - Host without byte accesses may hold both lane selects low.
// RULE_14 - Sleep low enters sleep; host keeps sleep high for any access.
// RULE_15 - Writes are nonvolatile at once; no busy period or polling needed.
// RULE_16 - Device refuses array access while supply is below its minimum.
// RULE_17 - Array splits into 8 blocks, each with its own write protection.
// RULE_18 - Protection changes by six reads, three writes, a final read. The model keeps PROT_MASK fixed.
// RULE_19 - While sleep is low the device ignores all other pins.
// RULE_20 - Raising select starts precharge; host keeps it high the minimum time.
// RULE_21 - During a write a lane whose select is high keeps its stored byte.
// RULE_22 - A write into a protected block leaves stored data unchanged.
package fpw_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int COL_W = 2;
  localparam int CLK_PERIOD_NS = 10;
  // Access time before read data is sampled or write strobe may rise
  localparam int T_ACCESS_NS = 55;
  localparam int T_ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Page access time within an open row
  localparam int T_PAGE_NS = 25;
  localparam int T_PAGE_CYC = (T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Least select-high precharge time
  localparam int T_PRECHARGE_NS = 55;
  localparam int T_PRECHARGE_CYC = (T_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Wait after sleep release before the first access
  localparam int T_SLEEP_EXIT_NS = 450;
  localparam int T_SLEEP_EXIT_CYC = (T_SLEEP_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    FPW_IDLE,
    FPW_SETUP,
    FPW_ACCESS,
    FPW_PRECHARGE,
    FPW_SLEEP,
    FPW_WAKE
  } fpw_state_t;
endpackage : fpw_pkg

// ---- rtl/fpw_timer.sv ----
// Down-counting cycle timer for the host controller
`timescale 1ns/10ps
`default_nettype none
module fpw_timer
  import fpw_pkg::*;
#(
  parameter int WIDTH = CNT_W
)
(
  input wire logic mclk_i,  // System clock
  input wire logic arst_n_i,  // Async reset, active low
  input wire logic load_i,  // Load pulse
  input wire logic [WIDTH-1:0] count_i,  // Cycles to count
  output logic done_o  // High while count is zero and no load is applied
);
  // Refuse widths narrower than 4 bits
  if (WIDTH < 4)
  begin : g_width_check
    $error("fpw_timer: WIDTH too small");
  end
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  // Next count
  always_comb
  begin
    cnt_next = cnt_reg;
    if (load_i)
    begin
      cnt_next = count_i;
    end
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - 1'b1;
    end
  end
  // Count register
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end
  assign done_o = (cnt_reg == '0) && !load_i;
endmodule // fpw_timer
`default_nettype wire

// ---- rtl/fpw_host.sv ----
// Host controller driving the parallel word-port memory pins
`timescale 1ns/10ps
`default_nettype none
module fpw_host
  import fpw_pkg::*;
#(
  parameter int A_W = ADDR_W,
  parameter int D_W = DATA_W
)
(
  input wire logic mclk_i,  // System clock
  input wire logic arst_n_i,  // Async reset, active low
  input wire logic req_i,  // Request strobe, taken when ready_o
  input wire logic req_write_i,  // 1 write, 0 read
  input wire logic [A_W-1:0] req_addr_i,  // Word address
  input wire logic [D_W-1:0] req_wdata_i,  // Write data
  input wire logic req_upper_i,  // Access upper byte
  input wire logic req_lower_i,  // Access lower byte
  input wire logic req_hold_i,  // Keep select low for a page follow-up
  input wire logic sleep_req_i,  // Level: request sleep
  output logic ready_o,  // Host may issue a request
  output logic done_o,  // One-cycle pulse at access end
  output logic [D_W-1:0] rdata_o,  // Read data, valid with done_o
  output logic select_n_o,  // Chip select pin
  output logic write_n_o,  // Write strobe pin
  output logic oe_n_o,  // Output enable pin
  output logic upper_lane_n_o,  // Upper byte lane select
  output logic lower_lane_n_o,  // Lower byte lane select
  output logic sleep_n_o,  // Sleep pin
  output logic [A_W-1:0] word_addr_o,  // Address pins
  input wire logic [D_W-1:0] data_io_i,  // Data bus level in
  output logic [D_W-1:0] data_io_o,  // Data bus drive value
  output logic data_io_oe_o  // High while host drives the bus
);
  if (A_W != ADDR_W || D_W != DATA_W)
  begin : g_width_check
    $error("fpw_host: only the documented widths are served");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  fpw_state_t state_reg, state_next;
  logic sel_reg, sel_next, wr_reg, wr_next, oe_reg, oe_next;
  logic up_reg, up_next, lo_reg, lo_next, slp_reg, slp_next;
  logic ready_reg, ready_next, done_reg, done_next, doe_reg, doe_next;
  logic open_reg, open_next;  // Row open with select low
  logic pend_reg, pend_next, wdir_reg, wdir_next;  // Request held behind a precharge, and its direction
  logic [A_W-1:0] addr_reg, addr_next;
  logic [D_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
  logic tload;
  logic [CNT_W-1:0] tcount;
  logic tdone;

  fpw_timer #(.WIDTH(CNT_W)) u_timer (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .load_i(tload),
    .count_i(tcount),
    .done_o(tdone)
  );

  // Same-row test: only the column bits may differ for a page access
  function automatic logic same_row(input logic [A_W-1:0] a, input logic [A_W-1:0] b);
    same_row = (a[A_W-1:COL_W] == b[A_W-1:COL_W]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    sel_next = sel_reg;
    wr_next = wr_reg;
    oe_next = oe_reg;
    up_next = up_reg;
    lo_next = lo_reg;
    slp_next = slp_reg;
    ready_next = 1'b0;
    done_next = 1'b0;
    doe_next = doe_reg;
    open_next = open_reg;
    pend_next = pend_reg;
    wdir_next = wdir_reg;
    addr_next = addr_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    tload = 1'b0;
    tcount = '0;
    case (state_reg)
      FPW_IDLE:
      begin
        ready_next = !sleep_req_i;
        if (sleep_req_i)
        begin
          // Sleep only after select is released and precharged
          sel_next = 1'b0;  // RULE_20
          open_next = 1'b0;
          if (open_reg)
          begin
            tload = 1'b1;
            tcount = CNT_W'(T_PRECHARGE_CYC);
            state_next = FPW_PRECHARGE;
          end
          else
          begin
            slp_next = 1'b0;  // RULE_14 RULE_19
            state_next = FPW_SLEEP;
          end
        end
        else if (req_i && ready_reg)
        begin
          ready_next = 1'b0;
          addr_next = req_addr_i;  // RULE_01 RULE_18
          wd_next = req_wdata_i;
          wdir_next = req_write_i;
          up_next = req_upper_i;  // RULE_11 RULE_12 RULE_13
          lo_next = req_lower_i;  // RULE_11 RULE_12 RULE_13
          if (open_reg && !same_row(req_addr_i, addr_reg))
          begin
            // New row: release select and precharge first
            sel_next = 1'b0;  // RULE_05
            open_next = 1'b0;
            pend_next = 1'b1;
            tload = 1'b1;
            tcount = CNT_W'(T_PRECHARGE_CYC);
            state_next = FPW_PRECHARGE;
          end
          else
          begin
            // Page access if row open, else fresh select fall
            state_next = FPW_SETUP;  // RULE_04 RULE_06
          end
        end
        else if (open_reg && !req_hold_i)
        begin
          sel_next = 1'b0;  // RULE_20
          open_next = 1'b0;
          ready_next = 1'b0;
          tload = 1'b1;
          tcount = CNT_W'(T_PRECHARGE_CYC);
          state_next = FPW_PRECHARGE;
        end
      end
      FPW_SETUP:
      begin
        // Address is stable one cycle before select falls or strobe falls
        sel_next = 1'b1;  // RULE_03
        open_next = 1'b1;
        wr_next = wdir_reg;
        oe_next = !wdir_reg;  // RULE_09 RULE_10
        doe_next = wdir_reg;  // RULE_02
        tload = 1'b1;
        tcount = open_reg ? CNT_W'(T_PAGE_CYC) : CNT_W'(T_ACCESS_CYC);
        state_next = FPW_ACCESS;
      end
      FPW_ACCESS:
      begin
        if (tdone)
        begin
          // Strobe rise commits the write; no busy wait follows
          wr_next = 1'b0;  // RULE_07 RULE_08 RULE_15
          oe_next = 1'b0;
          doe_next = 1'b0;
          rd_next = data_io_i;
          done_next = 1'b1;
          ready_next = 1'b1;
          state_next = FPW_IDLE;
        end
      end
      FPW_SLEEP:
      begin
        if (!sleep_req_i)
        begin
          slp_next = 1'b1;
          tload = 1'b1;
          tcount = CNT_W'(T_SLEEP_EXIT_CYC);
          state_next = FPW_WAKE;
        end
      end
      default:
      begin
        // Precharge or sleep exit; a request held behind the precharge goes on at once
        if (tdone)
        begin
          state_next = pend_reg ? FPW_SETUP : FPW_IDLE;
          pend_next = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= FPW_IDLE;
      sel_reg <= 1'b0;
      wr_reg <= 1'b0;
      oe_reg <= 1'b0;
      up_reg <= 1'b0;
      lo_reg <= 1'b0;
      slp_reg <= 1'b1;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      doe_reg <= 1'b0;
      open_reg <= 1'b0;
      addr_reg <= '0;
      wd_reg <= '0;
      rd_reg <= '0;
      wdir_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      wr_reg <= wr_next;
      oe_reg <= oe_next;
      up_reg <= up_next;
      lo_reg <= lo_next;
      slp_reg <= slp_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      doe_reg <= doe_next;
      open_reg <= open_next;
      addr_reg <= addr_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      pend_reg <= pend_next;
      wdir_reg <= wdir_next;
    end
  end

  // Pin outputs straight from flip-flops
  assign select_n_o = !sel_reg;
  assign write_n_o = !wr_reg;
  assign oe_n_o = !oe_reg;
  assign upper_lane_n_o = !up_reg;
  assign lower_lane_n_o = !lo_reg;
  assign sleep_n_o = slp_reg;
  assign word_addr_o = addr_reg;
  assign data_io_o = wd_reg;
  assign data_io_oe_o = doe_reg;
  assign ready_o = ready_reg;
  assign done_o = done_reg;
  assign rdata_o = rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_release;
    $rose(select_n_o);
  endsequence
  sequence s_precharge;
    select_n_o [*6];
  endsequence
  property p_precharge;
    @(posedge mclk_i) disable iff (!arst_n_i) s_release |-> s_precharge;
  endproperty
  a_precharge: assert property (p_precharge) else $error("select high shorter than precharge"); // RULE_20
  property p_sleep_idle;
    @(posedge mclk_i) disable iff (!arst_n_i) !sleep_n_o |-> select_n_o && write_n_o;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("access while sleeping"); // RULE_14
  property p_no_clash;
    @(posedge mclk_i) disable iff (!arst_n_i) data_io_oe_o |-> oe_n_o;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("bus driven with output enable low"); // RULE_02
  property p_write_len;
    @(posedge mclk_i) disable iff (!arst_n_i) $fell(write_n_o) |-> !write_n_o [*3];
  endproperty
  a_write_len: assert property (p_write_len) else $error("write strobe too short"); // RULE_07
  property p_wdata_stable;
    @(posedge mclk_i) disable iff (!arst_n_i) !write_n_o |-> data_io_oe_o && $stable(data_io_o);
  endproperty
  a_wdata_stable: assert property (p_wdata_stable) else $error("write data not held"); // RULE_07
  property p_addr_stable;
    @(posedge mclk_i) disable iff (!arst_n_i) !select_n_o && !$fell(select_n_o) && !$rose(select_n_o)
      && $changed(word_addr_o) |-> word_addr_o[ADDR_W-1:COL_W] == $past(word_addr_o[ADDR_W-1:COL_W]);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("row changed under select"); // RULE_04
  property p_done_after;
    @(posedge mclk_i) disable iff (!arst_n_i) $fell(select_n_o) |-> ##[5:7] done_o;
  endproperty
  a_done_after: assert property (p_done_after) else $error("access not closed in time"); // RULE_03
  property p_wake;
    @(posedge mclk_i) disable iff (!arst_n_i) $rose(sleep_n_o) |-> !ready_o [*8];
  endproperty
  a_wake: assert property (p_wake) else $error("request allowed before sleep exit"); // RULE_14
endmodule // fpw_host
`default_nettype wire

// ---- dv/fpw_mem_model.sv ----
// Behavioural model of the parallel word-port memory device
`timescale 1ns/10ps
`default_nettype none
module fpw_mem_model
  import fpw_pkg::*;
#(
  parameter logic [7:0] PROT_MASK = 8'h80
)
(
  input wire logic select_n_i,  // Select
  input wire logic write_n_i,  // Write strobe
  input wire logic oe_n_i,  // Output enable
  input wire logic upper_lane_n_i,  // Upper lane
  input wire logic lower_lane_n_i,  // Lower lane
  input wire logic sleep_n_i,  // Sleep
  input wire logic supply_ok_i,  // Supply above minimum
  input wire logic [ADDR_W-1:0] word_addr_i,  // Address pins
  input wire logic [DATA_W-1:0] data_i,  // Bus level
  output logic [DATA_W-1:0] data_o,  // Read data
  output logic [1:0] lane_oe_o  // Lane drive enables
);
  logic [DATA_W-1:0] mem [int];
  logic [15:0] row = '0;
  logic [DATA_W-1:0] wd, d;
  logic [1:0] col, wln;
  logic pg = 1'b0, wl = 1'b0, valid = 1'b0, act;
  realtime t0 = 0;
  ////////////////////////////////////////
  // Select fall opens a row and latches the row address bits 17:2
  always @(negedge select_n_i)
  begin
    if (sleep_n_i)
    begin
      row = word_addr_i[17:2];
      t0 = $realtime;
      pg = 1'b0;
    end
  end
  // Address change alone starts a new cycle, in page when the row holds
  always @(word_addr_i)
  begin
    if (!select_n_i && sleep_n_i && $realtime > t0)
    begin
      pg = (word_addr_i[17:2] == row);
      row = word_addr_i[17:2];
      t0 = $realtime;
    end
  end
  // Fine-grain tracking of access time and write operands
  always
  begin
    #1;
    wl = !write_n_i && !select_n_i && sleep_n_i;
    if (wl)
      {wd, wln, col} = {data_i, upper_lane_n_i, lower_lane_n_i, word_addr_i[1:0]};
    valid = ($realtime - t0) >= (pg ? T_PAGE_NS : T_ACCESS_NS);
    data_o = mem.exists({row, word_addr_i[1:0]}) ? mem[{row, word_addr_i[1:0]}] : 16'h0000;
  end
  // Strobe or select rise stores the word at once, no busy time
  always @(posedge write_n_i or posedge select_n_i)
  begin
    if (wl && supply_ok_i && !PROT_MASK[row[15:13]])
    begin
      d = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
      if (!wln[1])
        d[15:8] = wd[15:8];
      if (!wln[0])
        d[7:0] = wd[7:0];
      mem[{row, col}] = d;
    end
    wl = 1'b0;
  end
  // Lanes drive only for a settled read with output enable low
  assign act = !select_n_i && !oe_n_i && write_n_i && sleep_n_i && supply_ok_i && valid;
  assign lane_oe_o = {act && !upper_lane_n_i, act && !lower_lane_n_i};
endmodule // fpw_mem_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking testbench of the word-port host controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fpw_pkg::*;
  localparam logic [7:0] PROT = 8'h80;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, req_i = 1'b0, req_write_i = 1'b0, req_upper_i = 1'b1;
  logic req_lower_i = 1'b1, req_hold_i = 1'b0, sleep_req_i = 1'b0, supply_ok = 1'b1;
  logic [ADDR_W-1:0] req_addr_i = '0, word_addr_o;
  logic [DATA_W-1:0] req_wdata_i = '0, rdata_o, data_io_o, bus, bus_q = '0, dev_d, dev_m;
  logic ready_o, done_o, select_n_o, write_n_o, oe_n_o, upper_lane_n_o, lower_lane_n_o, sleep_n_o, data_io_oe_o;
  logic [1:0] dev_oe;
  logic [DATA_W-1:0] ref_mem [int];
  int num_errors = 0, n_compared = 0;
  fpw_host i_fpw_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_upper_i(req_upper_i), .req_lower_i(req_lower_i),
    .req_hold_i(req_hold_i), .sleep_req_i(sleep_req_i), .ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .select_n_o(select_n_o), .write_n_o(write_n_o), .oe_n_o(oe_n_o), .upper_lane_n_o(upper_lane_n_o),
    .lower_lane_n_o(lower_lane_n_o), .sleep_n_o(sleep_n_o), .word_addr_o(word_addr_o), .data_io_i(bus),
    .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o));
  fpw_mem_model #(.PROT_MASK(PROT)) i_fpw_mem_model (.select_n_i(select_n_o), .write_n_i(write_n_o),
    .oe_n_i(oe_n_o), .upper_lane_n_i(upper_lane_n_o), .lower_lane_n_i(lower_lane_n_o), .sleep_n_i(sleep_n_o),
    .supply_ok_i(supply_ok), .word_addr_i(word_addr_o), .data_i(bus), .data_o(dev_d), .lane_oe_o(dev_oe));
  ////////////////////////////////////////
  // Wire level: host, else device lanes, else a pattern changing every cycle
  assign dev_m = {{8{dev_oe[1]}}, {8{dev_oe[0]}}};
  assign bus = data_io_oe_o ? data_io_o : (dev_m & dev_d) | (~dev_m & ~bus_q);
  always @(posedge mclk_i) bus_q <= bus;
  // Clock
  initial forever #5 mclk_i = ~mclk_i;
  // Both parties must never drive the bus together
  always @(negedge mclk_i)
    if (data_io_oe_o === 1'b1 && dev_oe !== 2'b00) chk("bus contention", 1'b1, 1'b0);
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // One access, checked against the reference memory; lat 0 means bound only
  task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln,
                        input logic hold, input int lat);
    logic [15:0] m, e;
    int n;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    e = ref_mem.exists(a) ? ref_mem[a] : 16'h0000;
    while (ready_o !== 1'b1) @(negedge mclk_i);
    {req_i, req_write_i, req_addr_i, req_wdata_i, req_upper_i, req_lower_i, req_hold_i} = {1'b1, w, a, d, ln, hold};
    @(negedge mclk_i);
    req_i = 1'b0;
    n = 1;
    while (done_o !== 1'b1 && n < 40)
    begin
      @(negedge mclk_i);
      n++;
    end
    if (lat > 0) chk("latency", n, lat);
    else chk("latency bound", n <= T_ACCESS_CYC + T_PRECHARGE_CYC + 4, 1'b1);
    if (w && supply_ok && !PROT[a[17:15]])
      ref_mem[a] = (e & ~m) | (d & m);
    else if (!w)
      chk("read data", rdata_o & m, e & m);
  endtask
  // Watchdog
  initial
  begin
    #500000;
    num_errors++;
    report_and_stop();
  end
  // Main sequence
  initial
  begin
    logic [17:0] a;
    void'($urandom(32'hCD65));
    repeat (3) @(negedge mclk_i);
    arst_n_i = 1'b1;
    repeat (20) @(negedge mclk_i);
    access(1'b1, 18'h00000, 16'hA5C3, 2'b11, 1'b0, T_ACCESS_CYC + 3);
    access(1'b1, 18'h3FFFF, 16'h5A3C, 2'b11, 1'b0, 0);
    repeat (20) @(negedge mclk_i);
    access(1'b0, 18'h00000, 16'h0000, 2'b11, 1'b0, T_ACCESS_CYC + 3);
    access(1'b0, 18'h3FFFF, 16'h0000, 2'b11, 1'b0, 0);
    // Page writes then page reads within one row
    a = {3'd2, 13'h0155, 2'b00};
    access(1'b1, a, 16'h1111, 2'b11, 1'b1, 0);
    for (int c = 1; c < 4; c++) access(1'b1, a | 18'(c), 16'(c * 16'h2222), 2'b11, 1'b1, T_PAGE_CYC + 3);
    for (int c = 0; c < 4; c++) access(1'b0, a | 18'(c), 16'h0000, 2'b11, c < 3, T_PAGE_CYC + 3);
    // Byte lanes, protected block, supply drop
    access(1'b1, a, 16'hABCD, 2'b10, 1'b0, 0);
    access(1'b0, a, 16'h0000, 2'b11, 1'b0, 0);
    access(1'b0, a, 16'h0000, 2'b01, 1'b0, 0);
    access(1'b1, 18'h3C000, 16'h7777, 2'b11, 1'b0, 0);
    access(1'b0, 18'h3C000, 16'h0000, 2'b11, 1'b0, 0);
    supply_ok = 1'b0;
    access(1'b1, 18'h00000, 16'h0F0F, 2'b11, 1'b0, 0);
    supply_ok = 1'b1;
    access(1'b0, 18'h00000, 16'h0000, 2'b11, 1'b0, 0);
    // Random traffic over a small pool touching every block
    repeat (80)
    begin
      a = {3'($urandom_range(0, 7)), 13'h0ABC, 2'($urandom_range(0, 3))};
      access(1'($urandom), a, 16'($urandom), 2'($urandom_range(1, 3)), 1'($urandom), 0);
    end
    access(1'b0, a, 16'h0000, 2'b11, 1'b0, 0);
    // Protection change pattern: six reads, three writes, one read, served in order
    for (int i = 0; i < 10; i++)
      access(i >= 6 && i < 9, {3'd1, 13'((i == 9) ? 8 : i), 2'b00}, (i == 8) ? 16'h005A : 16'h00A5,
             2'b11, 1'b0, 0);
    // Sleep entry and exit
    sleep_req_i = 1'b1;
    for (int i = 0; i < 100 && sleep_n_o !== 1'b0; i++) @(negedge mclk_i);
    chk("sleep pin", sleep_n_o, 1'b0);
    repeat (20) @(negedge mclk_i);
    sleep_req_i = 1'b0;
    access(1'b0, 18'h3FFFF, 16'h0000, 2'b11, 1'b0, 0);
    // Reset in mid-run keeps the stored words
    arst_n_i = 1'b0;
    @(negedge mclk_i);
    chk("pins in reset", {select_n_o, write_n_o, oe_n_o, upper_lane_n_o, lower_lane_n_o, sleep_n_o,
        data_io_oe_o, ready_o, done_o}, 9'b111111000);
    arst_n_i = 1'b1;
    repeat (10) @(negedge mclk_i);
    access(1'b0, 18'h00000, 16'h0000, 2'b11, 1'b0, 0);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
